// File: pkg/spg_map.vh
// Register offsets, field positions and reset values of the stop-mode gating controller
`ifndef SPG_MAP_VH
`define SPG_MAP_VH

`define SPG_ADDR_W          4
`define SPG_DATA_W          8

`define SPG_OFF_CTRL0       4'h0
`define SPG_OFF_CTRL1       4'h1
`define SPG_OFF_STAT        4'h2
`define SPG_OFF_EVENT       4'h3

`define SPG_CTRL0_LVDSTOP   0
`define SPG_CTRL0_DBGEN     1
`define SPG_CTRL0_TRE       2
`define SPG_CTRL0_TSENSE    3
`define SPG_CTRL0_SEND      4
`define SPG_CTRL0_DIRECT    5
`define SPG_CTRL0_DEEPSEL   6
`define SPG_CTRL0_ADCEN     7

`define SPG_CTRL1_SAMPLO    0
`define SPG_CTRL1_SAMPHI    1
`define SPG_CTRL1_LFREN     2

`define SPG_EVT_DEEPWAKE    0
`define SPG_EVT_TRESTART    1

`define SPG_CTRL0_RST       8'h00
`define SPG_CTRL1_RST       8'h00

`define SPG_SAMP_ON_CYC     16'h0004
`define SPG_SAMP_SHORT_CYC  16'h0040
`define SPG_SAMP_LONG_CYC   16'h0400
`define SPG_WAKE_RST_CYC    4'h2

`endif

// File: design/spg_sync.v
// Two-flop synchroniser for levels arriving from outside the clock domain
module spg_sync (
   input  wire clk,
   input  wire reset,
   input  wire din,
   output reg  dout_q
);
   reg meta_q;

   // First stage feeds only the second stage
   always @(posedge clk) begin
      if (reset) begin
         meta_q <= 1'b0;
         dout_q <= 1'b0;
      end else begin
         meta_q <= din;
         dout_q <= meta_q;
      end
   end
endmodule

// File: design/spg_lf_sampler.v
// Periodic duty-cycle timer for the low-frequency receiver detectors
`include "spg_map.vh"

module spg_lf_sampler #(
   parameter [15:0] ON_CYC    = `SPG_SAMP_ON_CYC,
   parameter [15:0] SHORT_CYC = `SPG_SAMP_SHORT_CYC,
   parameter [15:0] LONG_CYC  = `SPG_SAMP_LONG_CYC
) (
   input  wire       clk,
   input  wire       reset,
   input  wire       enable,
   input  wire [1:0] sel,
   output reg        det_on_q
);
   reg  [15:0] cnt_q;
   wire [15:0] period;

   assign period = sel[0] ? LONG_CYC : SHORT_CYC;

   // Counter restarts whenever sampling is off so each stop begins with a window
   always @(posedge clk) begin
      if (reset || !enable || !sel[1]) begin
         cnt_q <= 16'h0000;
      end else if (cnt_q >= period - 16'h0001) begin
         cnt_q <= 16'h0000;
      end else begin
         cnt_q <= cnt_q + 16'h0001;
      end
   end

   // Select 0 keeps detectors off, 1 continuous, 2 and 3 periodic
   always @(posedge clk) begin
      if (reset || !enable) begin
         det_on_q <= 1'b0;
      end else begin
         case (sel)
            2'b00:   det_on_q <= 1'b0;
            2'b01:   det_on_q <= 1'b1;
            default: det_on_q <= (cnt_q < ON_CYC);
         endcase
      end
   end
endmodule

// File: design/spg_stop_ctrl.v
// Stop-mode power and clock gating controller
//
// Operation
// - Medium oscillator on in stop only for measurement or radio
// - High oscillator halted in every stop mode
// - Periodic wakeup unit always clocked
// - Converter always uses its own asynchronous clock
// - Converter keeps running in retained stop
// - Converter reset on leaving deepest stop
// - Receiver detectors follow sampling selection in stop
// - Timer clock stopped on any stop entry
// - Timer reset after deepest stop wakeup
// - Regulator standby except retained stop with lvd/debug
// - Temperature restart powered in stop only if enabled
// - Temperature restart resumes from reset vector
// - Radio powered during transmit or direct send
// - Radio stays powered after transmit while send set
// - Pressure cell powered only during scheduled measurement
// - Acceleration cell powered only during scheduled measurement
// - Temperature sensor powered only on processor command
// - Deepest request with lvd-in-stop becomes retained stop
// - Deepest stop wakeup restarts like power-on reset
`include "spg_map.vh"

module spg_stop_ctrl #(
   parameter [15:0] SAMP_ON_CYC    = `SPG_SAMP_ON_CYC,
   parameter [15:0] SAMP_SHORT_CYC = `SPG_SAMP_SHORT_CYC,
   parameter [15:0] SAMP_LONG_CYC  = `SPG_SAMP_LONG_CYC
) (
   input  wire                   clk,
   input  wire                   reset,
   input  wire [`SPG_ADDR_W-1:0] addr,
   input  wire [`SPG_DATA_W-1:0] wr_data,
   input  wire                   wr_en,
   input  wire                   rd_en,
   output reg  [`SPG_DATA_W-1:0] rd_data_q,
   input  wire                   stop_req,
   input  wire                   wake_pin,
   input  wire                   temp_limit_pin,
   input  wire                   smi_pressure_busy,
   input  wire                   smi_accel_busy,
   input  wire                   radio_tx_busy,
   output reg                    stop_ack_q,
   output reg                    mfo_en_q,
   output reg                    hfo_en_q,
   output reg                    pwu_clk_en_q,
   output reg                    adc_clk_async_q,
   output reg                    adc_clk_en_q,
   output reg                    adc_reset_q,
   output reg                    tmr_clk_en_q,
   output reg                    tmr_reset_q,
   output reg                    reg_full_q,
   output reg                    trestart_pwr_q,
   output reg                    reset_vector_q,
   output reg                    radio_pwr_q,
   output reg                    pcell_pwr_q,
   output reg                    gcell_pwr_q,
   output reg                    tsense_pwr_q,
   output reg                    lfr_det_pwr_q
);
   localparam [2:0] ST_RUN   = 3'b000;
   localparam [2:0] ST_ENTER = 3'b001;
   localparam [2:0] ST_GATE  = 3'b010;
   localparam [2:0] ST_STOP  = 3'b011;
   localparam [2:0] ST_WAKE  = 3'b100;

   reg  [2:0]             state_q;
   reg  [2:0]             state_d;
   reg                    in_stop_q;
   reg                    deep_q;
   reg                    deep_wake_q;
   reg  [3:0]             wake_cnt_q;
   reg  [`SPG_DATA_W-1:0] ctrl0_q;
   reg  [`SPG_DATA_W-1:0] ctrl1_q;
   reg                    evt_deep_q;
   reg                    evt_trst_q;
   reg                    tx_seen_q;
   reg  [`SPG_DATA_W-1:0] rd_mux;
   wire                   wake_s;
   wire                   temp_limit_s;
   wire                   lf_sample_on;
   wire                   lvd_stop;
   wire                   dbg_en;
   wire                   temp_restart_enable;
   wire                   send;
   wire                   direct;
   wire                   trestart_hit;
   wire                   wake_hit;
   wire                   deep_exit;
   wire                   clr_deep;
   wire                   clr_trst;

   // Stop variant as resolved from the request and the protection bits
   function resolve_deep;
      input deep_sel;
      input lvd_in_stop;
      input dbg;
      begin
         resolve_deep = deep_sel & ~lvd_in_stop & ~dbg;
      end
   endfunction

   // Enable of a unit that may run in stop only under a condition
   function gate_in_stop;
      input stopped;
      input run_en;
      input stop_en;
      begin
         gate_in_stop = stopped ? stop_en : run_en;
      end
   endfunction

   assign lvd_stop = ctrl0_q[`SPG_CTRL0_LVDSTOP];
   assign dbg_en   = ctrl0_q[`SPG_CTRL0_DBGEN];
   assign temp_restart_enable      = ctrl0_q[`SPG_CTRL0_TRE];
   assign send     = ctrl0_q[`SPG_CTRL0_SEND];
   assign direct   = ctrl0_q[`SPG_CTRL0_DIRECT];

   // Pins are asynchronous to the controller clock
   spg_sync u_sync_wake (
      .clk    (clk),
      .reset  (reset),
      .din    (wake_pin),
      .dout_q (wake_s)
   );

   spg_sync u_sync_temp (
      .clk    (clk),
      .reset  (reset),
      .din    (temp_limit_pin),
      .dout_q (temp_limit_s)
   );

   spg_lf_sampler #(
      .ON_CYC    (SAMP_ON_CYC),
      .SHORT_CYC (SAMP_SHORT_CYC),
      .LONG_CYC  (SAMP_LONG_CYC)
   ) u_lf_sampler (
      .clk      (clk),
      .reset    (reset),
      .enable   (in_stop_q & ctrl1_q[`SPG_CTRL1_LFREN]),
      .sel      (ctrl1_q[`SPG_CTRL1_SAMPHI:`SPG_CTRL1_SAMPLO]),
      .det_on_q (lf_sample_on)
   );

   // Restart only possible while its circuit is powered in stop
   assign trestart_hit = (state_q == ST_STOP) & temp_restart_enable & temp_limit_s;
   assign wake_hit     = (state_q == ST_STOP) & (wake_s | trestart_hit);
   assign deep_exit    = wake_hit & (deep_q | trestart_hit);

   always @* begin
      state_d = state_q;
      case (state_q)
         ST_RUN: begin
            if (stop_req) begin
               state_d = ST_ENTER;
            end
         end
         ST_ENTER: state_d = ST_GATE;
         ST_GATE:  state_d = ST_STOP;
         ST_STOP: begin
            if (wake_hit) begin
               state_d = ST_WAKE;
            end
         end
         ST_WAKE: begin
            if (wake_cnt_q == 4'h0) begin
               state_d = ST_RUN;
            end
         end
         default: state_d = ST_RUN;
      endcase
   end

   // Request and variant taken in one cycle, gates follow, then acknowledge
   always @(posedge clk) begin
      if (reset) begin
         state_q     <= ST_RUN;
         in_stop_q   <= 1'b0;
         deep_q      <= 1'b0;
         deep_wake_q <= 1'b0;
         wake_cnt_q  <= 4'h0;
         stop_ack_q  <= 1'b0;
      end else begin
         state_q    <= state_d;
         stop_ack_q <= (state_q == ST_STOP) & ~wake_hit;
         if (state_q == ST_RUN && stop_req) begin
            in_stop_q <= 1'b1;
            deep_q    <= resolve_deep(ctrl0_q[`SPG_CTRL0_DEEPSEL], lvd_stop, dbg_en);
         end
         if (wake_hit) begin
            in_stop_q   <= 1'b0;
            deep_wake_q <= deep_exit;
            wake_cnt_q  <= `SPG_WAKE_RST_CYC;
         end else if (state_q == ST_WAKE && wake_cnt_q != 4'h0) begin
            wake_cnt_q <= wake_cnt_q - 4'h1;
         end
         if (state_q == ST_RUN) begin
            deep_wake_q <= 1'b0;
         end
      end
   end

   // Remembers a finished transmission so the radio stays up while send holds
   always @(posedge clk) begin
      if (reset || !send) begin
         tx_seen_q <= 1'b0;
      end else if (radio_tx_busy) begin
         tx_seen_q <= 1'b1;
      end
   end

   // Gating outputs, the stop-dependent ones all updated from the same registered stop flag
   always @(posedge clk) begin
      if (reset) begin
         mfo_en_q        <= 1'b1;
         hfo_en_q        <= 1'b1;
         pwu_clk_en_q    <= 1'b1;
         adc_clk_async_q <= 1'b1;
         adc_clk_en_q    <= 1'b0;
         tmr_clk_en_q    <= 1'b1;
         reg_full_q      <= 1'b1;
         trestart_pwr_q  <= 1'b0;
         radio_pwr_q     <= 1'b0;
         pcell_pwr_q     <= 1'b0;
         gcell_pwr_q     <= 1'b0;
         tsense_pwr_q    <= 1'b0;
         lfr_det_pwr_q   <= 1'b0;
      end else begin
         mfo_en_q <= gate_in_stop(in_stop_q, 1'b1,
                        smi_pressure_busy | smi_accel_busy | radio_tx_busy);
         hfo_en_q        <= ~in_stop_q;
         pwu_clk_en_q    <= 1'b1;
         adc_clk_async_q <= 1'b1;
         // Deep stop gates the converter clock off; retained stop leaves it free to convert
         adc_clk_en_q <= ctrl0_q[`SPG_CTRL0_ADCEN]
                         & gate_in_stop(in_stop_q, 1'b1, ~deep_q);
         tmr_clk_en_q <= ~in_stop_q;
         reg_full_q   <= gate_in_stop(in_stop_q, 1'b1,
                            ~deep_q & (lvd_stop | dbg_en));
         trestart_pwr_q <= gate_in_stop(in_stop_q, temp_restart_enable, temp_restart_enable);
         radio_pwr_q <= gate_in_stop(in_stop_q,
                           send | radio_tx_busy,
                           radio_tx_busy | (send & direct) | tx_seen_q);
         pcell_pwr_q   <= smi_pressure_busy;
         gcell_pwr_q   <= smi_accel_busy;
         tsense_pwr_q  <= ctrl0_q[`SPG_CTRL0_TSENSE];
         lfr_det_pwr_q <= ctrl1_q[`SPG_CTRL1_LFREN]
                          & gate_in_stop(in_stop_q, 1'b1, lf_sample_on);
      end
   end

   // Deep stop exit behaves as a power-on restart of the converter and timer
   always @(posedge clk) begin
      if (reset) begin
         adc_reset_q    <= 1'b1;
         tmr_reset_q    <= 1'b1;
         reset_vector_q <= 1'b0;
      end else begin
         adc_reset_q    <= deep_wake_q & (state_q == ST_WAKE);
         tmr_reset_q    <= deep_wake_q & (state_q == ST_WAKE);
         reset_vector_q <= deep_wake_q & (state_q == ST_WAKE) & (wake_cnt_q == 4'h0);
      end
   end

   assign clr_deep = wr_en & (addr == `SPG_OFF_EVENT) & wr_data[`SPG_EVT_DEEPWAKE];
   assign clr_trst = wr_en & (addr == `SPG_OFF_EVENT) & wr_data[`SPG_EVT_TRESTART];

   // Control registers; a new event beats a clear in the same cycle
   always @(posedge clk) begin
      if (reset) begin
         ctrl0_q    <= `SPG_CTRL0_RST;
         ctrl1_q    <= `SPG_CTRL1_RST;
         evt_deep_q <= 1'b0;
         evt_trst_q <= 1'b0;
      end else begin
         if (wr_en && addr == `SPG_OFF_CTRL0) begin
            ctrl0_q <= wr_data;
         end
         if (wr_en && addr == `SPG_OFF_CTRL1) begin
            ctrl1_q <= {5'h00, wr_data[2:0]};
         end
         if (deep_exit) begin
            evt_deep_q <= 1'b1;
         end else if (clr_deep) begin
            evt_deep_q <= 1'b0;
         end
         if (trestart_hit) begin
            evt_trst_q <= 1'b1;
         end else if (clr_trst) begin
            evt_trst_q <= 1'b0;
         end
      end
   end

   always @* begin
      case (addr)
         `SPG_OFF_CTRL0: rd_mux = ctrl0_q;
         `SPG_OFF_CTRL1: rd_mux = ctrl1_q;
         `SPG_OFF_STAT:  rd_mux = {lfr_det_pwr_q, radio_pwr_q, reg_full_q, mfo_en_q,
                                   hfo_en_q, adc_clk_en_q, deep_q, in_stop_q};
         `SPG_OFF_EVENT: rd_mux = {6'h00, evt_trst_q, evt_deep_q};
         default:        rd_mux = 8'h00;
      endcase
   end

   // Read data valid only in the cycle after the strobe
   always @(posedge clk) begin
      if (reset) begin
         rd_data_q <= 8'h00;
      end else begin
         rd_data_q <= rd_en ? rd_mux : 8'h00;
      end
   end
endmodule

// File: bench/spg_props.sv
// Port-level assertions for the stop-mode gating controller
module spg_props (
   input wire clk,
   input wire reset,
   input wire stop_req,
   input wire smi_pressure_busy,
   input wire smi_accel_busy,
   input wire radio_tx_busy,
   input wire stop_ack_q,
   input wire mfo_en_q,
   input wire hfo_en_q,
   input wire pwu_clk_en_q,
   input wire adc_clk_async_q,
   input wire adc_reset_q,
   input wire tmr_clk_en_q,
   input wire tmr_reset_q,
   input wire reset_vector_q,
   input wire pcell_pwr_q,
   input wire gcell_pwr_q
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   wire [2:0] busy = {smi_pressure_busy, smi_accel_busy, radio_tx_busy};

   hfo_stop_a: assert property (stop_ack_q |-> !hfo_en_q)
      else $error("high oscillator on in stop");
   tmr_stop_a: assert property (stop_ack_q |-> !tmr_clk_en_q)
      else $error("timer clock on in stop");
   pwu_on_a: assert property (pwu_clk_en_q)
      else $error("wakeup unit clock gated");
   adc_async_a: assert property (adc_clk_async_q)
      else $error("converter not on its own clock");
   mfo_need_a: assert property (stop_ack_q && $past(stop_ack_q) && $stable(busy)
      |-> mfo_en_q == (|busy)) else $error("medium oscillator does not follow demand");
   ack_order_a: assert property ($rose(stop_ack_q) |-> $past(stop_req, 4))
      else $error("stop acknowledge at wrong time");
   pcell_only_a: assert property (pcell_pwr_q |-> smi_pressure_busy || $past(smi_pressure_busy))
      else $error("pressure cell on without measurement");
   gcell_only_a: assert property (gcell_pwr_q |-> smi_accel_busy || $past(smi_accel_busy))
      else $error("accel cell on without measurement");
   rst_len_a: assert property ($rose(adc_reset_q) |->
      (adc_reset_q && tmr_reset_q) [*3] ##1 !adc_reset_q) else $error("wake reset length");
   vec_pulse_a: assert property ($rose(reset_vector_q) |-> adc_reset_q ##1 !reset_vector_q)
      else $error("restart pulse wrong");
   wake_gates_a: assert property ($fell(stop_ack_q) |-> ##1 (hfo_en_q && mfo_en_q))
      else $error("clocks not restored after wake");

   cover property ($rose(stop_ack_q));
   cover property ($rose(reset_vector_q));
   cover property (stop_ack_q && mfo_en_q);
endmodule

bind spg_stop_ctrl spg_props u_props (.clk, .reset, .stop_req, .smi_pressure_busy,
   .smi_accel_busy, .radio_tx_busy, .stop_ack_q, .mfo_en_q, .hfo_en_q, .pwu_clk_en_q,
   .adc_clk_async_q, .adc_reset_q, .tmr_clk_en_q, .tmr_reset_q, .reset_vector_q,
   .pcell_pwr_q, .gcell_pwr_q);

// File: bench/spg_core_model.sv
// Processor core model: issues stop requests and wakes the block after a lag
module spg_core_model (
   input  wire       clk,
   input  wire       reset,
   input  wire       stop_go,
   input  wire       wake_go,
   input  wire [3:0] lag,
   input  wire       stop_ack_q,
   output reg        stop_req,
   output reg        wake_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   reg [3:0] cnt;
   reg       armed;
   always @(posedge clk) begin
      if (reset) begin
         stop_req <= 1'b0;
         wake_pin <= 1'b0;
         armed    <= 1'b0;
         cnt      <= 4'h0;
      end else begin
         // A new stop only while no stop is acknowledged
         stop_req <= stop_go & ~stop_ack_q;
         if (wake_go & stop_ack_q) begin
            armed <= 1'b1;
            cnt   <= lag;
         end else if (armed && cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
         end else if (armed) begin
            wake_pin <= 1'b1;
            armed    <= 1'b0;
         end
         // Held until the block has left stop, since the pin is synchronised
         if (wake_pin & ~stop_ack_q) begin
            wake_pin <= 1'b0;
         end
      end
   end
endmodule

// File: bench/stop_mode_power_gating_tb_top.sv
// Self-checking bench for the stop-mode gating controller
module stop_mode_power_gating_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic       clk, reset, wr_en, rd_en, stop_go, wake_go, temp_pin, pres, accel, tx, rd_seen;
   logic [3:0] addr, lag;
   logic [7:0] wr_data, r;
   wire  [7:0] rd_data_q;
   wire        stop_req, wake_pin, ack, medium_freq_osc, high_freq_osc, periodic_wakeup_unit, adc_as, adc_en, adc_rst, tmr_en;
   wire        tmr_rst, reg_full, tr_pwr, rvec, radio, pcell, gcell, ts, low_freq_receiver;
   int         err_total, checks, rv_cnt, rs_cnt, cyc;
   logic [7:0] exp_q[$];
   logic [8:0] tbl[6] = '{9'h040, 9'h0C1, 9'h0C2, 9'h080, 9'h134, 9'h018};

   // Short sampling periods keep the run brief
   spg_stop_ctrl #(.SAMP_ON_CYC(16'h0002), .SAMP_SHORT_CYC(16'h0008),
      .SAMP_LONG_CYC(16'h0010)) DUT (.clk(clk), .reset(reset), .addr(addr),
      .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data_q(rd_data_q),
      .stop_req(stop_req), .wake_pin(wake_pin), .temp_limit_pin(temp_pin),
      .smi_pressure_busy(pres), .smi_accel_busy(accel), .radio_tx_busy(tx),
      .stop_ack_q(ack), .mfo_en_q(medium_freq_osc), .hfo_en_q(high_freq_osc), .pwu_clk_en_q(periodic_wakeup_unit),
      .adc_clk_async_q(adc_as), .adc_clk_en_q(adc_en), .adc_reset_q(adc_rst),
      .tmr_clk_en_q(tmr_en), .tmr_reset_q(tmr_rst), .reg_full_q(reg_full),
      .trestart_pwr_q(tr_pwr), .reset_vector_q(rvec), .radio_pwr_q(radio),
      .pcell_pwr_q(pcell), .gcell_pwr_q(gcell), .tsense_pwr_q(ts), .lfr_det_pwr_q(low_freq_receiver));
   spg_core_model core (.clk(clk), .reset(reset), .stop_go(stop_go), .wake_go(wake_go),
      .lag(lag), .stop_ack_q(ack), .stop_req(stop_req), .wake_pin(wake_pin));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task complete_run;
      $display("checks %0d err_total %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task cmp(input string n, input logic [7:0] e, input logic [7:0] g);
      checks++;
      if (g !== e) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask

   task wr(input logic [3:0] ad, input logic [7:0] d);
      addr <= ad;
      wr_data <= d;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
      @(posedge clk);
   endtask

   task rd(input logic [3:0] ad, input logic [7:0] e);
      exp_q.push_back(e);
      addr <= ad;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      @(posedge clk);
   endtask

   task wait_ack(input logic v);
      int k;
      k = 0;
      do begin
         @(negedge clk);
         k++;
      end while (ack !== v && k < 30);
      cmp("stop_ack_q", {7'h00, v}, {7'h00, ack});
      @(posedge clk);
   endtask

   task stop_cycle(input logic [7:0] c0, input logic [7:0] c1, input logic tw);
      logic [2:0] b;
      logic       de, rad, lf, rf;
      int         rv0;
      int         rs0;
      de = c0[6] & ~c0[0] & ~c0[1];
      b = 3'($urandom);
      b[0] = b[0] | (c0[4] & ~c0[5]);
      rad = b[0] | (c0[4] & c0[5]);
      lf = c1[2] & (c1[1:0] == 2'h1);
      rf = ~de & (c0[0] | c0[1]);
      wr(4'h0, c0);
      wr(4'h1, c1);
      {pres, accel, tx} <= b;
      stop_go <= 1'b1;
      @(posedge clk);
      stop_go <= 1'b0;
      wait_ack(1'b1);
      repeat (2) @(posedge clk);
      #1;
      cmp("hfo", 8'h00, high_freq_osc);
      cmp("tmr_clk", 8'h00, tmr_en);
      cmp("mfo", |b, medium_freq_osc);
      cmp("pcell", b[2], pcell);
      cmp("gcell", b[1], gcell);
      cmp("reg_full", rf, reg_full);
      cmp("adc_clk", c0[7] & ~de, adc_en);
      cmp("trestart", c0[2], tr_pwr);
      cmp("tsense", c0[3], ts);
      cmp("radio", rad, radio);
      cmp("lfr_det", lf, low_freq_receiver);
      cmp("pwu_clk", 8'h01, periodic_wakeup_unit);
      cmp("adc_async", 8'h01, adc_as);
      @(posedge clk);
      rd(4'h2, {lf, rad, rf, |b, 1'b0, c0[7] & ~de, de, 1'b1});
      tx <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
      cmp("radio_after", c0[4], radio);
      @(posedge clk);
      rv0 = rv_cnt;
      rs0 = rs_cnt;
      if (tw) begin
         temp_pin <= 1'b1;
      end else begin
         lag <= 4'($urandom_range(0, 6));
         wake_go <= 1'b1;
         @(posedge clk);
         wake_go <= 1'b0;
      end
      wait_ack(1'b0);
      temp_pin <= 1'b0;
      {pres, accel} <= 2'h0;
      repeat (8) @(posedge clk);
      cmp("restarts", {7'h00, de | tw}, 8'(rv_cnt - rv0));
      cmp("wake_resets", (de | tw) ? 8'h03 : 8'h00, 8'(rs_cnt - rs0));
      // A temperature restart also takes the deep-wake path, so both event bits set
      rd(4'h3, {6'h00, tw, de | tw});
      wr(4'h3, 8'h03);
      rd(4'h3, 8'h00);
   endtask

   always @(posedge clk) begin
      if (rd_seen)
         cmp("rd_data_q", exp_q.pop_front(), rd_data_q);
      rd_seen <= rd_en;
      if (rvec === 1'b1)
         rv_cnt++;
      if (adc_rst === 1'b1 && tmr_rst === 1'b1)
         rs_cnt++;
      cyc++;
      // Whole sequence takes well under a thousand cycles
      if (cyc == 5000) begin
         err_total++;
         complete_run;
      end
   end

   initial begin
      {reset, wr_en, rd_en, stop_go, wake_go, temp_pin, pres, accel, tx} = 9'h100;
      {addr, lag, wr_data, rd_seen} = 17'h0_0000;
      void'($urandom(69056));
      repeat (6) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      rd(4'h0, 8'h00);
      rd(4'h1, 8'h00);
      rd(4'h2, 8'h38);
      wr(4'h9, 8'hFF);
      rd(4'h9, 8'h00);
      wr(4'h2, 8'hFF);
      rd(4'h2, 8'h38);
      r = 8'($urandom);
      wr(4'h1, r);
      rd(4'h1, r & 8'h07);
      r = 8'($urandom);
      wr(4'h0, r);
      rd(4'h0, r);
      for (int i = 0; i < 6; i++) begin
         stop_cycle(tbl[i][7:0], i[0] ? 8'h05 : 8'h04, tbl[i][8]);
      end
      complete_run;
   end
endmodule
